// ---- include/ctp_params.svh ----
/*
 Constants of the cascadable timer and port block: register offsets,
 bit positions, reset values and divider counts.
 Assumes a byte-wide register port with an 8-bit address.
*/
`ifndef CTP_PARAMS_SVH
`define CTP_PARAMS_SVH

// Register offsets
`define CTP_OFS_CTL      8'h4b
`define CTP_OFS_CNTLO    8'h4c
`define CTP_OFS_CNTHI    8'h4d
`define CTP_OFS_DATA     8'h4e
`define CTP_OFS_OE       8'h4f

// Control register fields
`define CTP_CTL_GFALL    0
`define CTP_CTL_LOWRAP   1
`define CTP_CTL_HIWRAP   2
`define CTP_CTL_GATE     3
`define CTP_CTL_SELA     4
`define CTP_CTL_SELB     5
`define CTP_CTL_CLK_LSB  6

// Data register fields
`define CTP_DAT_COMPON   6
`define CTP_DAT_CASCADE  7

// Output enable register field
`define CTP_OE_CLK_LSB   6

// Widths, reset values and counter maximum
`define CTP_NPINS        6
`define CTP_BYTE_RST     8'h00
`define CTP_PINS_RST     6'h00
`define CTP_CNT_MAX      8'hff

// Auxiliary clock divider
`define CTP_ACLK_DIV     16'h0600
`define CTP_DIV_W        16

`endif

// ---- include/ctp_pkg.sv ----
/*
 Types of the cascadable timer and port block.
 Assumes ctp_params.svh for numeric constants.
*/
package ctp_pkg;

    // Clock source select codes
    typedef enum logic [1:0] {
        CTP_CLK_EDGE = 2'h0,
        CTP_CLK_AUX  = 2'h1,
        CTP_CLK_MAIN = 2'h2,
        CTP_CLK_MAN2 = 2'h3
    } ctp_clk_e;

    // Gate select codes, {gate_select_b, gate_select_a}
    typedef enum logic [1:0] {
        CTP_GATE_OFF = 2'h0,
        CTP_GATE_ON  = 2'h1,
        CTP_GATE_PIN = 2'h2,
        CTP_GATE_CMP = 2'h3
    } ctp_gate_e;

    typedef logic [7:0] ctp_byte_t;

endpackage

// ---- include/ctp_cnt_if.sv ----
/*
 Carrier between the block top and one 8-bit counter slice.
 Assumes the slice and the top share one clock.
*/
`timescale 1ns/1ps
interface ctp_cnt_if;
    logic       tick;
    logic       gate;
    logic       wrEn;
    logic [7:0] wrData;
    logic [7:0] count;
    logic       carry;
    logic       wrap;

    modport ctl (output tick, gate, wrEn, wrData, input count, carry, wrap);
    modport cnt (input tick, gate, wrEn, wrData, output count, carry, wrap);
endinterface

// ---- core/ctp_counter8.sv ----
/*
 One 8-bit up-counter slice with carry output and wrap pulse.
 Assumes tick is a one-cycle enable pulse of the selected clock.
*/
`timescale 1ns/1ps
`include "ctp_params.svh"
module ctp_counter8 (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Counter carrier
    ctp_cnt_if.cnt    cnt
);
    import ctp_pkg::*;

    logic [7:0] count_r;
    logic [7:0] count_nxt;

    always_comb begin
        count_nxt = count_r;
        if (cnt.wrEn) begin
            count_nxt = cnt.wrData;
        end else if (cnt.tick && cnt.gate) begin
            count_nxt = count_r + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= `CTP_BYTE_RST;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign cnt.count = count_r;
    assign cnt.carry = (count_r == `CTP_CNT_MAX);
    // Wrap counts a carry fall by increment only, so a write never counts as a wrap
    assign cnt.wrap  = cnt.carry && cnt.tick && cnt.gate && !cnt.wrEn;

endmodule // ctp_counter8

// ---- core/ctp_timer_port.sv ----
/*
 Cascadable timer and port block: two 8-bit counters or one 16-bit
 counter, gate and clock source selection, wrap and gate-fall flags
 with one interrupt request, six tri-state outputs, comparator enable.
 Assumes a synchronous byte register port, the comparator output and
 the external gate pin on plain inputs, and the interrupt enable bit
 held outside the block.
*/
`timescale 1ns/1ps
`include "ctp_params.svh"
module ctp_timer_port #(
    parameter logic [`CTP_DIV_W-1:0] ACLK_DIV = `CTP_ACLK_DIV
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Register port
    input  wire logic [7:0]             regAddr,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    input  wire ctp_pkg::ctp_byte_t     regWrData,
    output ctp_pkg::ctp_byte_t          regRdData,
    // Comparator and external gate pin
    input  wire logic                   comparatorInput,
    input  wire logic                   externalGatePin,
    output logic                        comparatorOn,
    output logic                        compPinSelected,
    // Output pins
    output logic [`CTP_NPINS-1:0]       pinOut,
    output logic [`CTP_NPINS-1:0]       pinOe_n,
    // Interrupt
    input  wire logic                   portTimerIrqEnable,
    output logic                        irqReq
);
    import ctp_pkg::*;

    //------------------------------------------------------------
    // Functions
    //------------------------------------------------------------
    // Clock source pick; the edge source differs per counter
    function automatic logic clockPick(input logic [1:0] sel,
                                       input logic       edgeTick,
                                       input logic       auxTick);
        unique case (ctp_clk_e'(sel))
            CTP_CLK_EDGE: clockPick = edgeTick;
            CTP_CLK_AUX:  clockPick = auxTick;
            CTP_CLK_MAIN,
            CTP_CLK_MAN2: clockPick = 1'b1;
        endcase
    endfunction

    function automatic logic regHit(input logic [7:0] addr,
                                    input logic [7:0] ofs);
        regHit = (addr == ofs);
    endfunction

    //------------------------------------------------------------
    // Register state
    //------------------------------------------------------------
    logic       gateFall_r, gateFall_nxt;
    logic       lowWrap_r,  lowWrap_nxt;
    logic       highWrap_r, highWrap_nxt;
    logic [1:0] gateSel_r,  gateSel_nxt;
    logic [1:0] lowClk_r,   lowClk_nxt;
    logic [7:0] data_r,     data_nxt;
    logic [7:0] oe_r,       oe_nxt;
    logic       compLatch_r, compLatch_nxt;
    ctp_byte_t  rdData_r,   rdData_nxt;

    logic wrCtl;
    logic wrLo;
    logic wrHi;
    logic wrData;
    logic wrOe;

    assign wrCtl  = regWr && regHit(regAddr, `CTP_OFS_CTL);
    assign wrLo   = regWr && regHit(regAddr, `CTP_OFS_CNTLO);
    assign wrHi   = regWr && regHit(regAddr, `CTP_OFS_CNTHI);
    assign wrData = regWr && regHit(regAddr, `CTP_OFS_DATA);
    assign wrOe   = regWr && regHit(regAddr, `CTP_OFS_OE);

    //------------------------------------------------------------
    // Input synchronisers and edge detect
    //------------------------------------------------------------
    logic [1:0] cmpSync_r, cmpSync_nxt;
    logic [1:0] pinSync_r, pinSync_nxt;
    logic       cmpLast_r, cmpLast_nxt;
    logic       pinLast_r, pinLast_nxt;
    logic       cmpLvl;
    logic       pinLvl;
    logic       cmpRise;
    logic       pinRise;

    always_comb begin
        cmpSync_nxt = {cmpSync_r[0], comparatorInput};
        pinSync_nxt = {pinSync_r[0], externalGatePin};
        cmpLast_nxt = cmpSync_r[1];
        pinLast_nxt = pinSync_r[1];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmpSync_r <= 2'h0;
            pinSync_r <= 2'h0;
            cmpLast_r <= 1'b0;
            pinLast_r <= 1'b0;
        end else begin
            cmpSync_r <= cmpSync_nxt;
            pinSync_r <= pinSync_nxt;
            cmpLast_r <= cmpLast_nxt;
            pinLast_r <= pinLast_nxt;
        end
    end

    assign cmpLvl  = cmpSync_r[1];
    assign pinLvl  = pinSync_r[1];
    assign cmpRise = cmpLvl && !cmpLast_r;
    assign pinRise = pinLvl && !pinLast_r;

    //------------------------------------------------------------
    // Auxiliary clock divider
    //------------------------------------------------------------
    logic [`CTP_DIV_W-1:0] div_r, div_nxt;
    logic                  auxTick;

    assign auxTick = (div_r == ACLK_DIV - 1'b1);

    always_comb begin
        div_nxt = auxTick ? '0 : div_r + 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    //------------------------------------------------------------
    // Gate, clock selection and counters
    //------------------------------------------------------------
    logic      gate;
    logic      gateLast_r, gateLast_nxt;
    logic      gateSelLast_r, gateSelLast_nxt;
    logic      cascade;
    logic      lowTick;
    ctp_cnt_if loIf();
    ctp_cnt_if hiIf();

    assign cascade = data_r[`CTP_DAT_CASCADE];

    always_comb begin
        unique case (ctp_gate_e'(gateSel_r))
            CTP_GATE_OFF: gate = 1'b0;
            CTP_GATE_ON:  gate = 1'b1;
            CTP_GATE_PIN: gate = pinLvl;
            CTP_GATE_CMP: gate = cmpLvl;
        endcase
    end

    assign lowTick = clockPick(lowClk_r, cmpRise, auxTick);

    assign loIf.tick   = lowTick;
    assign loIf.gate   = gate;
    assign loIf.wrEn   = wrLo;
    assign loIf.wrData = regWrData;

    // Cascade shares the low clock and gates on the low carry
    assign hiIf.tick   = cascade ? lowTick
                       : clockPick(oe_r[`CTP_OE_CLK_LSB +: 2],
                                   pinRise, auxTick);
    assign hiIf.gate   = cascade ? (gate && loIf.carry) : 1'b1;
    assign hiIf.wrEn   = wrHi;
    assign hiIf.wrData = regWrData;

    ctp_counter8 u_low (
        .clk   (clk),
        .rst_n (rst_n),
        .cnt   (loIf.cnt)
    );

    ctp_counter8 u_high (
        .clk   (clk),
        .rst_n (rst_n),
        .cnt   (hiIf.cnt)
    );

    //------------------------------------------------------------
    // Flags and register updates
    //------------------------------------------------------------
    logic gateFallEvt;
    logic lowWrapEvt;
    logic highWrapEvt;

    // Fall not caused by a select change counts as an external event
    assign gateFallEvt = gateLast_r && !gate && !gateSelLast_r;
    // Wrap uses the gate of its own cycle, so a stop write in that cycle keeps it
    assign lowWrapEvt  = !cascade && loIf.wrap;
    assign highWrapEvt = hiIf.wrap;

    always_comb begin
        gateLast_nxt    = gate;
        gateSelLast_nxt = wrCtl
                        && (regWrData[`CTP_CTL_SELA +: 2] != gateSel_r);
        gateFall_nxt = gateFall_r | gateFallEvt;
        lowWrap_nxt  = lowWrap_r  | lowWrapEvt;
        highWrap_nxt = highWrap_r | highWrapEvt;
        gateSel_nxt  = gateSel_r;
        lowClk_nxt   = lowClk_r;
        data_nxt     = data_r;
        oe_nxt       = oe_r;
        if (wrCtl) begin
            gateFall_nxt = regWrData[`CTP_CTL_GFALL]  | gateFallEvt;
            lowWrap_nxt  = regWrData[`CTP_CTL_LOWRAP] | lowWrapEvt;
            highWrap_nxt = regWrData[`CTP_CTL_HIWRAP] | highWrapEvt;
            gateSel_nxt  = regWrData[`CTP_CTL_SELA +: 2];
            lowClk_nxt   = regWrData[`CTP_CTL_CLK_LSB +: 2];
        end
        if (wrData) begin
            data_nxt = regWrData;
        end
        if (wrOe) begin
            oe_nxt = regWrData;
        end
        compLatch_nxt = compLatch_r | data_r[`CTP_DAT_COMPON];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gateLast_r    <= 1'b0;
            gateSelLast_r <= 1'b0;
            gateFall_r    <= 1'b0;
            lowWrap_r     <= 1'b0;
            highWrap_r    <= 1'b0;
            gateSel_r     <= 2'h0;
            lowClk_r      <= 2'h0;
            data_r        <= `CTP_BYTE_RST;
            oe_r          <= `CTP_BYTE_RST;
            compLatch_r   <= 1'b0;
        end else begin
            gateLast_r    <= gateLast_nxt;
            gateSelLast_r <= gateSelLast_nxt;
            gateFall_r    <= gateFall_nxt;
            lowWrap_r     <= lowWrap_nxt;
            highWrap_r    <= highWrap_nxt;
            gateSel_r     <= gateSel_nxt;
            lowClk_r      <= lowClk_nxt;
            data_r        <= data_nxt;
            oe_r          <= oe_nxt;
            compLatch_r   <= compLatch_nxt;
        end
    end

    //------------------------------------------------------------
    // Read data
    //------------------------------------------------------------
    always_comb begin
        rdData_nxt = rdData_r;
        if (regRd) begin
            rdData_nxt = `CTP_BYTE_RST;
            if (regHit(regAddr, `CTP_OFS_CTL)) begin
                rdData_nxt = {lowClk_r, gateSel_r, gate,
                              highWrap_r, lowWrap_r, gateFall_r};
            end else if (regHit(regAddr, `CTP_OFS_CNTLO)) begin
                rdData_nxt = loIf.count;
            end else if (regHit(regAddr, `CTP_OFS_CNTHI)) begin
                rdData_nxt = hiIf.count;
            end else if (regHit(regAddr, `CTP_OFS_DATA)) begin
                rdData_nxt = data_r;
            end else if (regHit(regAddr, `CTP_OFS_OE)) begin
                rdData_nxt = oe_r;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_r <= `CTP_BYTE_RST;
        end else begin
            rdData_r <= rdData_nxt;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    assign regRdData       = rdData_r;
    assign comparatorOn    = data_r[`CTP_DAT_COMPON];
    assign compPinSelected = compLatch_r;
    assign pinOut          = data_r[`CTP_NPINS-1:0];
    assign pinOe_n         = ~oe_r[`CTP_NPINS-1:0];
    // Software-set low flag requests in either mode
    assign irqReq = portTimerIrqEnable
                  && (gateFall_r || lowWrap_r || highWrap_r);

endmodule // ctp_timer_port

// ---- verif/ctp_timer_port_asserts.sv ----
/*
 Checker for the timer and port block top, bound to ctp_timer_port.
 Assumes one clock domain and the active-low asynchronous reset.
*/
`timescale 1ns/1ps
`include "ctp_params.svh"
module ctp_timer_port_asserts #(
    parameter logic [`CTP_DIV_W-1:0] ACLK_DIV = `CTP_ACLK_DIV
) (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 rst_n,
    // Register port
    input wire logic [7:0]           regAddr,
    input wire logic                 regWr,
    input wire logic                 regRd,
    input wire ctp_pkg::ctp_byte_t   regWrData,
    input wire ctp_pkg::ctp_byte_t   regRdData,
    // Comparator and pins
    input wire logic                 comparatorInput,
    input wire logic                 externalGatePin,
    input wire logic                 comparatorOn,
    input wire logic                 compPinSelected,
    input wire logic [`CTP_NPINS-1:0] pinOut,
    input wire logic [`CTP_NPINS-1:0] pinOe_n,
    // Interrupt
    input wire logic                 portTimerIrqEnable,
    input wire logic                 irqReq
);
    import ctp_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic wrDat;
    logic wrOe;
    logic wrCtl;
    assign wrDat = regWr && regAddr == `CTP_OFS_DATA;
    assign wrOe  = regWr && regAddr == `CTP_OFS_OE;
    assign wrCtl = regWr && regAddr == `CTP_OFS_CTL;
    sequence s_flagWr;
        wrCtl && (|regWrData[2:0]);
    endsequence
    sequence s_irqOn;
        portTimerIrqEnable;
    endsequence
    chk_irq_gate: assert property (!portTimerIrqEnable |-> !irqReq)
        else $error("irq raised while disabled");
    chk_flag_irq: assert property (s_flagWr ##1 s_irqOn |-> irqReq)
        else $error("software flag gave no irq");
    chk_irq_fall: assert property ($fell(irqReq)
        |-> $fell(portTimerIrqEnable) || $past(wrCtl))
        else $error("irq dropped without software");
    chk_data_write: assert property (wrDat |=> pinOut == $past(regWrData[5:0])
        && comparatorOn == $past(regWrData[6]))
        else $error("data write not applied");
    chk_data_stable: assert property (!wrDat |=> $stable(pinOut) && $stable(comparatorOn))
        else $error("data outputs changed alone");
    chk_oe_write: assert property (wrOe |=> pinOe_n == ~$past(regWrData[5:0]))
        else $error("enable write not applied");
    chk_oe_stable: assert property (!wrOe |=> $stable(pinOe_n))
        else $error("enables changed alone");
    chk_oe_read: assert property (regRd && regAddr == `CTP_OFS_OE
        |=> regRdData[5:0] == ~$past(pinOe_n))
        else $error("enable readback wrong");
    chk_data_read: assert property (regRd && regAddr == `CTP_OFS_DATA
        |=> regRdData[5:0] == $past(pinOut) && regRdData[6] == $past(comparatorOn))
        else $error("data readback wrong");
    chk_pin_latch: assert property ($rose(comparatorOn) |=> compPinSelected)
        else $error("shared pin not switched");
    chk_pin_sticky: assert property (compPinSelected |=> compPinSelected)
        else $error("shared pin switched back");
    chk_pin_cause: assert property ($rose(compPinSelected) |-> $past(comparatorOn))
        else $error("shared pin switched without enable");
endmodule // ctp_timer_port_asserts

bind ctp_timer_port ctp_timer_port_asserts #(.ACLK_DIV(ACLK_DIV)) ctp_timer_port_asserts_i (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
    .regWrData(regWrData), .regRdData(regRdData), .comparatorInput(comparatorInput),
    .externalGatePin(externalGatePin), .comparatorOn(comparatorOn),
    .compPinSelected(compPinSelected), .pinOut(pinOut), .pinOe_n(pinOe_n),
    .portTimerIrqEnable(portTimerIrqEnable), .irqReq(irqReq));

// ---- verif/testbench.sv ----
/*
 Self-checking bench for the timer and port block.
 Assumes the design files, ctp_params.svh and ctp_pkg are compiled first.
*/
`timescale 1ns/1ps
`include "ctp_params.svh"
module testbench;
    import ctp_pkg::*;
    localparam logic [`CTP_DIV_W-1:0] DIV = 16'h0004;
    logic             clk;
    logic             rst_n;
    logic [7:0]       regAddr;
    logic             regWr;
    logic             regRd;
    ctp_byte_t        regWrData;
    ctp_byte_t        regRdData;
    logic             comparatorInput;
    logic             externalGatePin;
    logic             comparatorOn;
    logic             compPinSelected;
    logic [5:0]       pinOut;
    logic [5:0]       pinOe_n;
    logic             portTimerIrqEnable;
    logic             irqReq;
    ctp_byte_t        expQ[$];
    ctp_byte_t        mskQ[$];
    logic             rdPend;
    int               n_fail = 0;
    int               samples_checked = 0;
    ctp_byte_t        d;
    ctp_byte_t        e;
    logic             ge;
    int               seed;

    ctp_timer_port #(.ACLK_DIV(DIV)) ctp_timer_port_i (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
        .regWrData(regWrData), .regRdData(regRdData), .comparatorInput(comparatorInput),
        .externalGatePin(externalGatePin), .comparatorOn(comparatorOn),
        .compPinSelected(compPinSelected), .pinOut(pinOut), .pinOe_n(pinOe_n),
        .portTimerIrqEnable(portTimerIrqEnable), .irqReq(irqReq));

    task automatic wrap_up;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cmp(input ctp_byte_t got, input ctp_byte_t exp, input ctp_byte_t msk);
        samples_checked++;
        if ((got & msk) !== (exp & msk)) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input ctp_byte_t v);
        @(posedge clk);
        regAddr <= a;
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input ctp_byte_t v, input ctp_byte_t m);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        expQ.push_back(v);
        mskQ.push_back(m);
        @(posedge clk);
        regRd <= 1'b0;
        #1;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ----------------------------------------
    // Clock, watchdog and read monitor
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        idle(20000);
        n_fail++;
        wrap_up();
    end
    initial begin
        rdPend = 1'b0;
        forever begin
            @(posedge clk);
            #1;
            if (rdPend) begin
                cmp(regRdData, expQ.pop_front(), mskQ.pop_front());
            end
            rdPend = regRd;
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        regAddr = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        regWrData = 8'h00;
        comparatorInput = 1'b0;
        externalGatePin = 1'b0;
        portTimerIrqEnable = 1'b0;
        seed = $urandom(32'hb360353f);
        idle(4);
        #1;
        cmp({pinOe_n, irqReq, comparatorOn}, 8'hfc, 8'hff);
        cmp({pinOut, compPinSelected, irqReq}, 8'h00, 8'hff);
        @(posedge clk);
        rst_n <= 1'b1;
        rd(`CTP_OFS_CTL, 8'h00, 8'hff);
        rd(`CTP_OFS_DATA, 8'h00, 8'hff);
        rd(`CTP_OFS_OE, 8'h00, 8'hff);
        rd(8'h4a, 8'h00, 8'hff);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom) & 8'h3f;
            e = 8'($urandom) & 8'h3f;
            wr(`CTP_OFS_DATA, d);
            cmp({2'b00, pinOut}, d, 8'hff);
            wr(`CTP_OFS_OE, e);
            cmp({2'b00, ~pinOe_n}, e, 8'hff);
            rd(`CTP_OFS_DATA, d, 8'hff);
            rd(`CTP_OFS_OE, e, 8'hff);
        end
        wr(`CTP_OFS_OE, 8'h00);
        for (int g = 0; g < 8; g++) begin
            @(posedge clk);
            externalGatePin <= g[0];
            comparatorInput <= ~g[0];
            ge = (g[2:1] == 2'h0) ? 1'b0 : (g[2:1] == 2'h1) ? 1'b1
               : (g[2:1] == 2'h2) ? g[0] : ~g[0];
            wr(`CTP_OFS_CTL, {2'b10, 2'(g >> 1), 4'h0});
            idle(4);
            rd(`CTP_OFS_CTL, {2'b10, 2'(g >> 1), ge, 3'b000}, 8'hf8);
        end
        wr(`CTP_OFS_CTL, 8'h80);
        wr(`CTP_OFS_CNTLO, 8'hff);
        idle(5);
        rd(`CTP_OFS_CNTLO, 8'hff, 8'hff);
        wr(`CTP_OFS_CTL, 8'h90);
        idle(10);
        rd(`CTP_OFS_CTL, 8'h9a, 8'hff);
        cmp({7'h00, irqReq}, 8'h00, 8'hff);
        @(posedge clk);
        portTimerIrqEnable <= 1'b1;
        idle(1);
        #1;
        cmp({7'h00, irqReq}, 8'h01, 8'hff);
        wr(`CTP_OFS_CTL, 8'h80);
        cmp({7'h00, irqReq}, 8'h00, 8'hff);
        wr(`CTP_OFS_CNTHI, 8'hf0);
        wr(`CTP_OFS_OE, 8'h80);
        idle(40);
        rd(`CTP_OFS_CTL, 8'h84, 8'hff);
        wr(`CTP_OFS_CTL, 8'h40);
        wr(`CTP_OFS_CNTLO, 8'h00);
        wr(`CTP_OFS_CTL, 8'h50);
        idle(40);
        wr(`CTP_OFS_CTL, 8'h40);
        rd(`CTP_OFS_CNTLO, 8'h08, 8'hf8);
        wr(`CTP_OFS_CTL, 8'h80);
        wr(`CTP_OFS_OE, 8'h00);
        wr(`CTP_OFS_DATA, 8'h80);
        wr(`CTP_OFS_CNTLO, 8'hf0);
        wr(`CTP_OFS_CNTHI, 8'hff);
        wr(`CTP_OFS_CTL, 8'h90);
        idle(40);
        rd(`CTP_OFS_CTL, 8'h9c, 8'hff);
        wr(`CTP_OFS_CTL, 8'h80);
        rd(`CTP_OFS_CNTHI, 8'h00, 8'hff);
        wr(`CTP_OFS_CTL, 8'h80);
        cmp({7'h00, irqReq}, 8'h00, 8'hff);
        wr(`CTP_OFS_CTL, 8'h82);
        cmp({7'h00, irqReq}, 8'h01, 8'hff);
        wr(`CTP_OFS_DATA, 8'h00);
        @(posedge clk);
        externalGatePin <= 1'b1;
        wr(`CTP_OFS_CTL, 8'ha0);
        idle(5);
        externalGatePin <= 1'b0;
        idle(5);
        rd(`CTP_OFS_CTL, 8'ha1, 8'hff);
        wr(`CTP_OFS_CTL, 8'ha0);
        @(posedge clk);
        externalGatePin <= 1'b1;
        idle(5);
        wr(`CTP_OFS_CTL, 8'h80);
        idle(5);
        rd(`CTP_OFS_CTL, 8'h80, 8'hff);
        wr(`CTP_OFS_DATA, 8'h40);
        idle(2);
        #1;
        cmp({6'h00, comparatorOn, compPinSelected}, 8'h03, 8'hff);
        wr(`CTP_OFS_DATA, 8'h00);
        cmp({6'h00, comparatorOn, compPinSelected}, 8'h01, 8'hff);
        idle(3);
        if (expQ.size() != 0) begin
            n_fail++;
        end
        wrap_up();
    end
endmodule // testbench
